// File: verilog/rscd_defs.vh
// Constants for the reset strap configuration decoder.
// Assumes inclusion by bare name from design files.
`ifndef RSCD_DEFS_VH
`define RSCD_DEFS_VH

// Strap positions on the narrow interface address bus
`define RSCD_ADDR_W 21
`define RSCD_WIDE_SEL_HI 17
`define RSCD_WIDE_SEL_LO 16
`define RSCD_NARROW_SEL_HI 15
`define RSCD_NARROW_SEL_LO 14
`define RSCD_EEPROM_AUTOINIT_STRAP_BIT 13
`define RSCD_CELL_BIT 11

// Clock select codes
`define RSCD_CLK_EXT 2'h0
`define RSCD_CLK_DIV4 2'h1
`define RSCD_CLK_DIV6 2'h2
`define RSCD_CLK_RSVD 2'h3

// One-hot source encoding
`define RSCD_SRC_EXT 3'h1
`define RSCD_SRC_DIV4 3'h2
`define RSCD_SRC_DIV6 3'h4
`define RSCD_SRC_NONE 3'h0

// Defaults held in reset
`define RSCD_EEPROM_AUTOINIT_STRAP_DEF 1'h0
`define RSCD_CELL_DEF 1'h0

`endif

// File: verilog/rscd_clk_sel_decode.v
// Decodes one two-bit clock select strap into a one-hot source choice.
// Assumes a code that is already captured and stable.
`default_nettype none
`include "rscd_defs.vh"

module rscd_clk_sel_decode (
   input wire [1:0] sel_i,
   output reg [2:0] src_o,
   output reg reserved_o
);

   always @* begin
      src_o = `RSCD_SRC_NONE;
      reserved_o = 1'b0;
      case (sel_i)
         `RSCD_CLK_EXT: src_o = `RSCD_SRC_EXT;
         `RSCD_CLK_DIV4: src_o = `RSCD_SRC_DIV4;
         `RSCD_CLK_DIV6: src_o = `RSCD_SRC_DIV6;
         default: reserved_o = 1'b1;
      endcase
   end

endmodule // rscd_clk_sel_decode

`default_nettype wire

// File: verilog/rscd_strap_decoder.v
// Reset strap configuration decoder: captures address-pin straps once
// at reset release and holds the decoded modes until the next reset.
// Assumes straps are driven synchronously to clk_i while in reset.
// Assumes the board holds the strap levels through the first enabled
// clock edge after reset release; later pin traffic is ignored.
//
// Notes on behaviour
// - Sample address-pin straps at reset; captured levels set the modes.
// - Wide clock select: 00 external, 01 core/4, 10 core/6, 11 reserved.
// - Narrow clock select: 00 external, 01 core/4, 10 core/6, 11 reserved.
// - EEPROM autoinit strap: 0 disables host-bus EEPROM load, 1 enables.
// - Cell-port strap: 0 enables second serial port, 1 cell port.
`default_nettype none
`include "rscd_defs.vh"

module rscd_strap_decoder (
   input wire clk_i,
   input wire rst_b_i,
   input wire ce_i,
   input wire [`RSCD_ADDR_W-1:0] narrow_if_address_pins_i,
   input wire host_bus_enable_i,
   output reg [1:0] wide_if_clock_select_o,
   output reg [1:0] narrow_if_clock_select_o,
   output wire [2:0] wide_if_clk_src_o,
   output wire [2:0] narrow_if_clk_src_o,
   output wire clk_sel_reserved_o,
   output reg eeprom_autoinit_strap_o,
   output wire eeprom_autoinit_en_o,
   output reg cell_port_enable_strap_o,
   output wire cell_port_en_o,
   output wire second_serial_port_en_o,
   output reg straps_valid_o
);

   ////////////////////////////////////////////////////////////////////////
   // Usage
   //
   // Limitation: there is no filtering of the strap pins.  Whatever level
   // stands on the capture edge is taken, so a board that is still
   // settling its pulls at reset release gets that level for good.
   // Under an asynchronous reset the pins cannot be sampled inside reset
   // itself, hence the capture on the first enabled edge after release.
   // A low clock enable after release simply postpones that edge.
   // Unused address pins are deliberately ignored; they carry the
   // interface's ordinary address traffic once it starts running.

   ////////////////////////////////////////////////////////////////////////
   // Phases
   //
   // The loader only walks forward: it waits for the first enabled edge
   // after reset, takes the straps once, then locks until the next
   // reset.  No path leads back from the locked phase short of a reset,
   // which keeps later address traffic out of the decoded modes.

   localparam [1:0] ST_CAPTURE = 2'h0;
   localparam [1:0] ST_LOCKED = 2'h1;

   // Reset values of the captured fields
   localparam [1:0] SEL_DEF = `RSCD_CLK_EXT;
   localparam [0:0] EEPROM_AUTOINIT_STRAP_DEF = `RSCD_EEPROM_AUTOINIT_STRAP_DEF;
   localparam [0:0] CELL_DEF = `RSCD_CELL_DEF;

   ////////////////////////////////////////////////////////////////////////
   // Strap fields

   // The same pins carry bus addresses once the interface runs, so
   // these slices only mean anything on the capture edge.
   wire [1:0] wide_sel_pins;
   wire [1:0] narrow_sel_pins;
   wire eeprom_autoinit_strap_pin;
   wire cell_pin;

   assign wide_sel_pins =
      narrow_if_address_pins_i[`RSCD_WIDE_SEL_HI:`RSCD_WIDE_SEL_LO];
   assign narrow_sel_pins =
      narrow_if_address_pins_i[`RSCD_NARROW_SEL_HI:`RSCD_NARROW_SEL_LO];
   assign eeprom_autoinit_strap_pin = narrow_if_address_pins_i[`RSCD_EEPROM_AUTOINIT_STRAP_BIT];
   assign cell_pin = narrow_if_address_pins_i[`RSCD_CELL_BIT];

   ////////////////////////////////////////////////////////////////////////
   // State and next values

   reg [1:0] state_r;
   reg [1:0] state_nxt;
   reg load_nxt;
   reg straps_valid_nxt;
   reg [1:0] wide_sel_nxt;
   reg [1:0] narrow_sel_nxt;
   reg eeprom_autoinit_strap_nxt;
   reg cell_nxt;
   wire wide_rsvd;
   wire narrow_rsvd;

   // Phase transitions; the clock enable is applied in the register
   // processes so a low enable freezes phase and fields together.
   always @* begin
      state_nxt = state_r;
      load_nxt = 1'b0;
      case (state_r)
         ST_CAPTURE: begin
            load_nxt = 1'b1;
            state_nxt = ST_LOCKED;
         end
         ST_LOCKED: begin
            state_nxt = ST_LOCKED;
         end
         default: begin
            // An upset code must not reopen capture mid-run
            state_nxt = ST_LOCKED;
         end
      endcase
   end

   // Clock select codes: load once, otherwise hold what was taken
   always @* begin
      wide_sel_nxt = wide_if_clock_select_o;
      narrow_sel_nxt = narrow_if_clock_select_o;
      if (load_nxt) begin
         wide_sel_nxt = wide_sel_pins;
         narrow_sel_nxt = narrow_sel_pins;
      end
   end

   // Single strap bits and the valid flag, same load-once pattern
   always @* begin
      straps_valid_nxt = straps_valid_o;
      eeprom_autoinit_strap_nxt = eeprom_autoinit_strap_o;
      cell_nxt = cell_port_enable_strap_o;
      if (load_nxt) begin
         straps_valid_nxt = 1'b1;
         eeprom_autoinit_strap_nxt = eeprom_autoinit_strap_pin;
         cell_nxt = cell_pin;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Registers

   // Reset loads constants only; a reset branch that sampled the pins
   // would turn the reset line into a data path.
   always @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         state_r <= ST_CAPTURE;
      end else if (ce_i) begin
         state_r <= state_nxt;
      end
   end

   // Valid rises on the capture edge and stays up until reset
   always @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         straps_valid_o <= 1'b0;
      end else if (ce_i) begin
         straps_valid_o <= straps_valid_nxt;
      end
   end

   // Captured clock select codes
   always @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         wide_if_clock_select_o <= SEL_DEF;
         narrow_if_clock_select_o <= SEL_DEF;
      end else if (ce_i) begin
         wide_if_clock_select_o <= wide_sel_nxt;
         narrow_if_clock_select_o <= narrow_sel_nxt;
      end
   end

   // Captured single-bit straps
   always @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         eeprom_autoinit_strap_o <= EEPROM_AUTOINIT_STRAP_DEF;
         cell_port_enable_strap_o <= CELL_DEF;
      end else if (ce_i) begin
         eeprom_autoinit_strap_o <= eeprom_autoinit_strap_nxt;
         cell_port_enable_strap_o <= cell_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Decode

   rscd_clk_sel_decode u_wide_dec (
      .sel_i(wide_if_clock_select_o),
      .src_o(wide_if_clk_src_o),
      .reserved_o(wide_rsvd)
   );

   rscd_clk_sel_decode u_narrow_dec (
      .sel_i(narrow_if_clock_select_o),
      .src_o(narrow_if_clk_src_o),
      .reserved_o(narrow_rsvd)
   );

   assign clk_sel_reserved_o = wide_rsvd | narrow_rsvd;

   // Gated by the host-bus enable too, since a board breaking the low
   // strap rule must not start an EEPROM load on a dead peripheral.
   assign eeprom_autoinit_en_o =
      eeprom_autoinit_strap_o & host_bus_enable_i;

   assign cell_port_en_o = cell_port_enable_strap_o;
   assign second_serial_port_en_o = ~cell_port_enable_strap_o;

endmodule // rscd_strap_decoder

`default_nettype wire

// File: dv/rscd_monitor.sv
// Port checker for the strap decoder; bound at the foot of this file.
`default_nettype none
module rscd_monitor (input wire logic clk_i, rst_b_i, host_bus_enable_i,
   input wire logic straps_valid_o, clk_sel_reserved_o, cell_port_en_o,
   input wire logic eeprom_autoinit_strap_o, eeprom_autoinit_en_o,
   input wire logic cell_port_enable_strap_o, second_serial_port_en_o,
   input wire logic [20:0] narrow_if_address_pins_i,
   input wire logic [1:0] wide_if_clock_select_o, narrow_if_clock_select_o,
   input wire logic [2:0] wide_if_clk_src_o, narrow_if_clk_src_o);
   timeunit 1ns / 1ns;
   wire [20:0] p = narrow_if_address_pins_i;
   wire [1:0] w = wide_if_clock_select_o;
   wire [1:0] n = narrow_if_clock_select_o;
   wire [1:0] e = {eeprom_autoinit_strap_o, cell_port_enable_strap_o};
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_b_i);
   a_capture_codes: assert property ($rose(straps_valid_o) |->
      {w, n, e} == $past({p[17:13], p[11]})) else $error("capture");
   a_wide_decode: assert property (wide_if_clk_src_o ==
      {w == 2'h2, w == 2'h1, !w}) else $error("wide");
   a_narrow_decode: assert property (narrow_if_clk_src_o ==
      {n == 2'h2, n == 2'h1, !n} && clk_sel_reserved_o == (&w | &n))
      else $error("narrow");
   a_autoinit_gate: assert property (eeprom_autoinit_en_o ==
      (e[1] & host_bus_enable_i)) else $error("autoinit");
   a_cell_select: assert property (cell_port_en_o == e[0] &&
      second_serial_port_en_o != e[0]) else $error("cell");
   a_hold_after: assert property (straps_valid_o |=>
      straps_valid_o && $stable({w, n, e})) else $error("moved");
endmodule // rscd_monitor
bind rscd_strap_decoder rscd_monitor i_mon (.*);
`default_nettype wire

// File: dv/rscd_strap_drv.sv
// Board strap source: levels through reset, then moving bus traffic.
`default_nettype none
module rscd_strap_drv (input wire logic clk_i, rst_b_i, hbe_i, lean_i,
   input wire logic [20:0] strap_i, output logic [20:0] pins_o);
   timeunit 1ns / 1ns;
   logic [1:0] ph_r;
   // Straps last one edge only, so a late capture sees traffic
   always @(posedge clk_i or negedge rst_b_i)
      ph_r <= !rst_b_i ? 2'h2 : {1'h0, !ph_r[0]};
   assign pins_o = ph_r[1] ?
      strap_i & ~{7'h0, !hbe_i | lean_i, 1'h0, lean_i, 11'h0} :
      ~strap_i ^ {20'h0, ph_r[0]};
endmodule // rscd_strap_drv
`default_nettype wire

// File: dv/tb_rscd_strap_decoder.sv
// Random strap trials, one full reset each; assumes the bound checker.
`default_nettype none
module tb_rscd_strap_decoder;
   timeunit 1ns / 1ns;
   logic clk_i = 1'h0, rst_b_i = 1'h0, h = 1'h0, l = 1'h0;
   logic [20:0] s = 21'h0;
   wire logic [20:0] p;
   wire logic [16:0] o;
   int err_count = 0, num_checks = 0;
   rscd_strap_decoder i_dut (.clk_i, .rst_b_i, .ce_i(1'h1),
      .narrow_if_address_pins_i(p), .host_bus_enable_i(h),
      .straps_valid_o(o[16]), .wide_if_clock_select_o(o[15:14]),
      .narrow_if_clock_select_o(o[13:12]), .wide_if_clk_src_o(o[11:9]),
      .narrow_if_clk_src_o(o[8:6]), .clk_sel_reserved_o(o[5]),
      .eeprom_autoinit_strap_o(o[4]), .eeprom_autoinit_en_o(o[3]),
      .cell_port_enable_strap_o(o[2]), .cell_port_en_o(o[1]),
      .second_serial_port_en_o(o[0]));
   rscd_strap_drv i_brd (.clk_i, .rst_b_i, .hbe_i(h), .lean_i(l),
      .strap_i(s), .pins_o(p));
   task chk(input logic [16:0] a, b);
      num_checks++;
      if (a !== b) err_count++;
      if (a !== b) $display("wrong value %0t %h %h", $time, a, b);
   endtask
   task test_done;
      if (err_count == 0 && num_checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   function logic [16:0] want(input logic [1:0] w, n, input logic e, c);
      return {1'h1, w, n, w == 2'h2, w == 2'h1, !w, n == 2'h2, n == 2'h1,
         !n, &w | &n, e, e & h, c, c, !c};
   endfunction
   initial forever #50 clk_i = ~clk_i;
   initial begin
      void'($urandom(11));
      for (int i = 0; i < 24; i++) begin
         {s, h, l} = {21'($urandom), 1'($urandom), i > 3 && $urandom % 4 == 0};
         // First trials walk every select code, reserved one included
         if (i < 4) s[17:14] = {2{i[1:0]}};
         repeat (5) @(posedge clk_i);
         #1 chk(o, 17'h00241);
         rst_b_i = 1'h1;
         for (int k = 0; k < 4 && o[16] !== 1'h1; k++) @(posedge clk_i) #1;
         chk(o[16], 1'h1);
         if (o[16] !== 1'h1) test_done;
         repeat (3) @(posedge clk_i) #1;
         chk(o, want(s[17:16], s[15:14],
            s[13] & h & !l, s[11] & !l));
         rst_b_i = 1'h0;
      end
      test_done;
   end
endmodule // tb_rscd_strap_decoder
`default_nettype wire
